// ==== bench/ocd_decode_properties.sv ====
/*
 * concurrent checks on the ports of the opcode decoder.
 * assumes binding onto ocd_decode and the ocd_pkg types.
 */
`timescale 1ns/1ps

module ocd_decode_properties
  import ocd_pkg::*;
(
  input  wire logic ref_clk,     // core clock
  input  wire logic sys_rst,     // sync reset, high
  input  wire logic insn_valid,  // instruction offered
  input  ocd_insn_t insn,        // opcode and modrm
  input  wire logic insn_ready,  // decoder can take
  input  ocd_dec_t  dec,         // registered decode
  input  wire logic dec_valid,   // decode pulse
  input  wire logic exec_busy,   // clocks running
  input  wire logic exec_done,   // last clock
  input  ocd_seg_t  pend_seg,    // pending segment
  input  wire logic pend_ovr     // override pending
);
  // ------------------------------------------------------------
  // helper: clocks elapsed in the running instruction
  // ------------------------------------------------------------
  logic       take;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  assign take    = insn_valid && insn_ready;
  assign cnt_nxt = dec_valid ? 7'h1 : cnt_r + 7'h1;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) cnt_r <= 7'h0;
    else if (exec_busy) cnt_r <= cnt_nxt;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  take_to_valid_a: assert property (take |=> dec_valid && exec_busy)
    else $error("take without decode pulse");
  valid_needs_take_a: assert property (!take |=> !dec_valid)
    else $error("decode pulse without take");
  done_count_a: assert property (exec_done |-> cnt_nxt == dec.clocks)
    else $error("instruction length differs from clocks");
  busy_bound_a: assert property (dec_valid |-> ##[0:41] exec_done)
    else $error("instruction never completes");
  refuse_busy_a: assert property (exec_busy && !exec_done |-> !insn_ready)
    else $error("ready while busy");
  mem_form_a: assert property (dec_valid && dec.uses_modrm |->
    ((dec.op == OCD_EA_LOAD) ? !dec.mem_operand : dec.mem_operand == ($past(insn.modrm[7:6]) != 2'h3)))
    else $error("memory form mismatch");
  seg_load_a: assert property (dec_valid && dec.op == OCD_SEG_LOAD |->
    dec.clocks == (dec.mem_operand ? 7'h9 : 7'h2))
    else $error("segment load clocks");
  table_op_a: assert property (take && insn.opcode == 8'hd7 |=>
    dec.op == OCD_TABLE_LOOKUP && dec.clocks == 7'hb)
    else $error("table lookup decode");
  prefix_code_a: assert property (take && insn.opcode == 8'h2e |=> pend_ovr && pend_seg == OCD_SEG_CODE)
    else $error("code prefix not pending");
  alu_sum_a: assert property (dec_valid && dec.op == OCD_SUM && dec.uses_modrm && !dec.has_imm |->
    dec.clocks == (dec.mem_operand ? 7'ha : 7'h3))
    else $error("sum clocks");
  product_reg_a: assert property (take && insn.opcode == 8'hf6 && insn.modrm == 8'he0 |=>
    dec.op == OCD_PRODUCT && dec.clocks == 7'h1a)
    else $error("byte product decode");
  imm_size_a: assert property (take && insn.opcode[7:2] == 6'b100000 |=>
    dec.has_imm && dec.imm_bytes == (($past(insn.opcode[1:0]) == 2'b01) ? 2'h2 : 2'h1))
    else $error("immediate byte count");
  acc_imm_a: assert property (take && insn.opcode inside {8'h04, 8'h05, 8'h14, 8'h15, 8'h1c, 8'h1d,
    8'h2c, 8'h2d, 8'h3c, 8'h3d} |=> dec.has_imm && dec.imm_bytes == ($past(insn.opcode[0]) ? 2'h2 : 2'h1))
    else $error("accumulator immediate bytes");
  flags_only_a: assert property (dec_valid && dec.op == OCD_COMPARE |-> !dec.store_result)
    else $error("compare stores a result");
  carry_use_a: assert property (dec_valid |->
    dec.carry_in == (dec.op == OCD_SUM_CARRY || dec.op == OCD_DIFF_BORROW))
    else $error("carry use mismatch");
endmodule : ocd_decode_properties

bind ocd_decode ocd_decode_properties ocd_decode_properties_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .insn_valid(insn_valid), .insn(insn),
  .insn_ready(insn_ready), .dec(dec), .dec_valid(dec_valid), .exec_busy(exec_busy),
  .exec_done(exec_done), .pend_seg(pend_seg), .pend_ovr(pend_ovr));

// ==== bench/test_ocd_decode.sv ====
/*
 * self-checking bench for the opcode decoder: decode table, then
 * prefix, width and back-to-back cases. assumes ocd_pkg compiled first.
 */
`timescale 1ns/1ps

`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("mismatch %0t %s", $time, m); end end

module test_ocd_decode
  import ocd_pkg::*;
;
  typedef struct packed {
    logic [7:0] opc;
    logic [7:0] mrm;
    ocd_op_t    op;
    logic [6:0] clk;
  } ocd_row_t;

  logic      ref_clk = 1'b0;
  logic      sys_rst = 1'b1;
  logic      insn_valid = 1'b0;
  ocd_insn_t insn = '0;
  logic      insn_ready;
  ocd_dec_t  dec;
  logic      dec_valid;
  logic      exec_busy;
  logic      exec_done;
  ocd_seg_t  pend_seg;
  logic      pend_ovr;
  int        error_cnt = 0;
  int        cmp_count = 0;
  int        n;

  ocd_decode ocd_decode_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .insn_valid(insn_valid),
    .insn(insn), .insn_ready(insn_ready), .dec(dec), .dec_valid(dec_valid),
    .exec_busy(exec_busy), .exec_done(exec_done), .pend_seg(pend_seg), .pend_ovr(pend_ovr));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  ocd_row_t rows [42] = '{
    '{8'h8e, 8'hc0, OCD_SEG_LOAD, 7'h2}, '{8'h8e, 8'h06, OCD_SEG_LOAD, 7'h9},
    '{8'h8c, 8'hc0, OCD_SEG_STORE, 7'h2}, '{8'h8c, 8'h07, OCD_SEG_STORE, 7'hb},
    '{8'hd7, 8'h00, OCD_TABLE_LOOKUP, 7'hb},
    '{8'h8d, 8'h06, OCD_EA_LOAD, 7'h6}, '{8'h8d, 8'hc0, OCD_ILLEGAL, 7'h1},
    '{8'hc5, 8'h06, OCD_FAR_DATA, 7'h12}, '{8'hc4, 8'h46, OCD_FAR_EXTRA, 7'h12},
    '{8'hc4, 8'hc0, OCD_ILLEGAL, 7'h1},
    '{8'h9f, 8'h00, OCD_FLAGS_TO_AH, 7'h2}, '{8'h9e, 8'h00, OCD_AH_TO_FLAGS, 7'h3},
    '{8'h36, 8'h00, OCD_SEG_PREFIX, 7'h2}, '{8'h3e, 8'h00, OCD_SEG_PREFIX, 7'h2},
    '{8'h00, 8'hc0, OCD_SUM, 7'h3}, '{8'h03, 8'h06, OCD_SUM, 7'ha},
    '{8'h80, 8'hc0, OCD_SUM, 7'h4}, '{8'h81, 8'h16, OCD_SUM_CARRY, 7'h10},
    '{8'h83, 8'he8, OCD_DIFF, 7'h4}, '{8'h82, 8'h1e, OCD_DIFF_BORROW, 7'h10},
    '{8'h80, 8'hf8, OCD_COMPARE, 7'h3}, '{8'h81, 8'h3e, OCD_COMPARE, 7'ha},
    '{8'h04, 8'h00, OCD_SUM, 7'h3}, '{8'h15, 8'h00, OCD_SUM_CARRY, 7'h4},
    '{8'h2d, 8'h00, OCD_DIFF, 7'h4}, '{8'h1c, 8'h00, OCD_DIFF_BORROW, 7'h3},
    '{8'h3d, 8'h00, OCD_COMPARE, 7'h4}, '{8'h12, 8'hc0, OCD_SUM_CARRY, 7'h3},
    '{8'hff, 8'h06, OCD_PLUS_ONE, 7'hf}, '{8'h40, 8'h00, OCD_PLUS_ONE, 7'h3},
    '{8'hfe, 8'hc8, OCD_MINUS_ONE, 7'h3}, '{8'h4f, 8'h00, OCD_MINUS_ONE, 7'h3},
    '{8'h29, 8'h06, OCD_DIFF, 7'ha}, '{8'h1b, 8'h06, OCD_DIFF_BORROW, 7'ha},
    '{8'h3b, 8'hc0, OCD_COMPARE, 7'h3}, '{8'h38, 8'h06, OCD_COMPARE, 7'ha},
    '{8'hf6, 8'hd8, OCD_SIGN_CHANGE, 7'h3}, '{8'hf7, 8'h1e, OCD_SIGN_CHANGE, 7'ha},
    '{8'h37, 8'h00, OCD_ASCII_SUM_FIX, 7'h8}, '{8'h3f, 8'h00, OCD_ASCII_DIFF_FIX, 7'h7},
    '{8'hf7, 8'he0, OCD_PRODUCT, 7'h23}, '{8'hf6, 8'h26, OCD_PRODUCT, 7'h20}
  };

  task automatic report_and_stop;
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // bounded step to the next falling edge
  task automatic tick;
    @(negedge ref_clk);
    n++;
    if (n > 200) begin
      error_cnt++;
      $display("mismatch %0t wait limit", $time);
      report_and_stop();
    end
  endtask : tick

  // offer one instruction, then check decode and busy length
  task automatic run(input logic [7:0] o, input logic [7:0] m, input ocd_op_t eo, input logic [6:0] ec);
    logic [6:0] k;
    n = 0;
    k = 7'h0;
    insn_valid = 1'b1;
    insn = '{opcode: o, modrm: m};
    while (insn_ready !== 1'b1) tick();
    tick();
    insn_valid = 1'b0;
    `CHK(dec_valid, 1'b1, "no decode pulse")
    `CHK(dec.op, eo, "operation")
    `CHK(dec.clocks, ec, "clock count")
    while (exec_busy === 1'b1) begin
      k++;
      tick();
    end
    `CHK(k, ec, "busy length")
  endtask : run

  initial begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    `CHK(pend_seg, OCD_SEG_DATA, "default segment")
    `CHK(insn_ready, 1'b1, "ready after reset")
    foreach (rows[i]) run(rows[i].opc, rows[i].mrm, rows[i].op, rows[i].clk);
    // ------------------------------------------------------------
    // prefix then memory operand
    // ------------------------------------------------------------
    run(8'h2e, 8'h00, OCD_SEG_PREFIX, 7'h2);
    `CHK({pend_ovr, pend_seg}, {1'b1, OCD_SEG_CODE}, "prefix pending")
    run(8'h03, 8'h06, OCD_SUM, 7'ha);
    `CHK({dec.seg_override, dec.seg}, {1'b1, OCD_SEG_CODE}, "override carried")
    `CHK({dec.word, dec.reg_dest}, 2'h3, "word toward register")
    run(8'h26, 8'h00, OCD_SEG_PREFIX, 7'h2);
    `CHK({pend_ovr, pend_seg}, {1'b1, OCD_SEG_EXTRA}, "extra prefix")
    run(8'h00, 8'h07, OCD_SUM, 7'ha);
    `CHK({dec.word, dec.reg_dest, dec.seg}, {2'h0, OCD_SEG_EXTRA}, "byte toward memory")
    run(8'h27, 8'h00, OCD_BCD_SUM_FIX, 7'h4);
    `CHK(pend_ovr, 1'b0, "override cleared")
    run(8'h2f, 8'h00, OCD_BCD_DIFF_FIX, 7'h4);
    // ------------------------------------------------------------
    // held request refused during a product, taken at its end
    // ------------------------------------------------------------
    n = 0;
    insn_valid = 1'b1;
    insn = '{opcode: 8'hf6, modrm: 8'he0};
    tick();
    insn = '{opcode: 8'hd7, modrm: 8'h00};
    `CHK(insn_ready, 1'b0, "ready while busy")
    tick();
    while (dec_valid !== 1'b1) tick();
    insn_valid = 1'b0;
    `CHK(n, 27, "product spacing")
    `CHK(dec.op, OCD_TABLE_LOOKUP, "queued op")
    // ------------------------------------------------------------
    // reset in mid-run, over a running prefix
    // ------------------------------------------------------------
    n = 0;
    while (insn_ready !== 1'b1) tick();
    insn_valid = 1'b1;
    insn = '{opcode: 8'h36, modrm: 8'h00};
    tick();
    insn_valid = 1'b0;
    `CHK({exec_busy, pend_ovr}, 2'h3, "prefix running")
    sys_rst = 1'b1;
    tick();
    tick();
    sys_rst = 1'b0;
    `CHK({exec_busy, dec_valid, pend_ovr, insn_ready}, 4'h1, "state after reset")
    `CHK({dec.op, pend_seg}, {OCD_NONE, OCD_SEG_DATA}, "decode after reset")
    run(8'hd7, 8'h00, OCD_TABLE_LOOKUP, 7'hb);
    repeat (4) @(negedge ref_clk);
    report_and_stop();
  end
endmodule : test_ocd_decode

// ==== inc/ocd_pkg.sv ====
/*
 * types shared by the opcode decoder and its issue sequencer.
 * assumes ocd_regs.svh on the include path.
 */
package ocd_pkg;

  // ------------------------------------------------------------
  // operation classes
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    OCD_NONE,
    OCD_SEG_LOAD,
    OCD_SEG_STORE,
    OCD_TABLE_LOOKUP,
    OCD_EA_LOAD,
    OCD_FAR_DATA,
    OCD_FAR_EXTRA,
    OCD_FLAGS_TO_AH,
    OCD_AH_TO_FLAGS,
    OCD_SEG_PREFIX,
    OCD_SUM,
    OCD_SUM_CARRY,
    OCD_DIFF,
    OCD_DIFF_BORROW,
    OCD_COMPARE,
    OCD_PLUS_ONE,
    OCD_MINUS_ONE,
    OCD_SIGN_CHANGE,
    OCD_ASCII_SUM_FIX,
    OCD_BCD_SUM_FIX,
    OCD_ASCII_DIFF_FIX,
    OCD_BCD_DIFF_FIX,
    OCD_PRODUCT,
    OCD_ILLEGAL
  } ocd_op_t;

  typedef enum logic [1:0] {
    OCD_SEG_EXTRA = 2'h0,
    OCD_SEG_CODE  = 2'h1,
    OCD_SEG_STACK = 2'h2,
    OCD_SEG_DATA  = 2'h3
  } ocd_seg_t;

  // ------------------------------------------------------------
  // instruction bytes offered to the decoder
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
  } ocd_insn_t;

  // ------------------------------------------------------------
  // decoded result
  // ------------------------------------------------------------
  typedef struct packed {
    ocd_op_t    op;
    logic       word;
    logic       reg_dest;
    logic       mem_operand;
    logic       uses_modrm;
    logic       has_imm;
    logic [1:0] imm_bytes;
    logic       store_result;
    logic       carry_in;
    logic [2:0] reg_sel;
    ocd_seg_t   seg;
    logic       seg_override;
    logic [6:0] clocks;
  } ocd_dec_t;

endpackage : ocd_pkg

// ==== inc/ocd_regs.svh ====
/*
 * timing counts and opcode encodings for the opcode decode and timing block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH

// ------------------------------------------------------------
// clock rate
// ------------------------------------------------------------
`define OCD_CLK_HZ          40000000

// ------------------------------------------------------------
// opcode encodings
// ------------------------------------------------------------
`define OCD_OP_SEG_FROM_RM  8'h8e
`define OCD_OP_SEG_TO_RM    8'h8c
`define OCD_OP_TABLE        8'hd7
`define OCD_OP_EA_LOAD      8'h8d
`define OCD_OP_FAR_DATA     8'hc5
`define OCD_OP_FAR_EXTRA    8'hc4
`define OCD_OP_FLAGS_TO_AH  8'h9f
`define OCD_OP_AH_TO_FLAGS  8'h9e
`define OCD_OP_PFX_CODE     8'h2e
`define OCD_OP_PFX_STACK    8'h36
`define OCD_OP_PFX_DATA     8'h3e
`define OCD_OP_PFX_EXTRA    8'h26
`define OCD_OP_ASCII_SUM    8'h37
`define OCD_OP_BCD_SUM      8'h27
`define OCD_OP_ASCII_DIFF   8'h3f
`define OCD_OP_BCD_DIFF     8'h2f

// ------------------------------------------------------------
// clock counts (register form / memory form)
// ------------------------------------------------------------
`define OCD_T_SEG_LD_R      7'd2
`define OCD_T_SEG_LD_M      7'd9
`define OCD_T_SEG_ST_R      7'd2
`define OCD_T_SEG_ST_M      7'd11
`define OCD_T_TABLE         7'd11
`define OCD_T_EA_LOAD       7'd6
`define OCD_T_FAR_PTR       7'd18
`define OCD_T_FLAGS_TO_AH   7'd2
`define OCD_T_AH_TO_FLAGS   7'd3
`define OCD_T_PREFIX        7'd2
`define OCD_T_ALU_R         7'd3
`define OCD_T_ALU_M         7'd10
`define OCD_T_IMM_R         7'd4
`define OCD_T_IMM_M         7'd16
`define OCD_T_ACC_B         7'd3
`define OCD_T_ACC_W         7'd4
`define OCD_T_INCDEC_R      7'd3
`define OCD_T_INCDEC_M      7'd15
`define OCD_T_SHORT_INCDEC  7'd3
`define OCD_T_NEG_R         7'd3
`define OCD_T_NEG_M         7'd10
`define OCD_T_ASCII_SUM     7'd8
`define OCD_T_ASCII_DIFF    7'd7
`define OCD_T_BCD_FIX       7'd4
`define OCD_T_MULB_R        7'd26
`define OCD_T_MULW_R        7'd35
`define OCD_T_MULB_M        7'd32
`define OCD_T_MULW_M        7'd41
`define OCD_T_UNKNOWN       7'd1

`endif

// ==== rtl/ocd_clock_count.sv ====
/*
 * down counter that holds the core busy for a decoded instruction's clocks.
 * assumes a nonzero count on each load; runs on ref_clk with sync reset.
 */
`timescale 1ns/1ps
`include "ocd_regs.svh"

module ocd_clock_count
  import ocd_pkg::*;
#(
  parameter int CW = 7
) (
  input  wire logic          ref_clk,   // core clock
  input  wire logic          sys_rst,   // sync reset, high
  input  wire logic          load,      // start a new count
  input  wire logic [CW-1:0] clocks,    // total clocks of the instruction
  output logic               busy,      // counting
  output logic               last       // final clock of the instruction
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  assign cnt_nxt = load ? clocks : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign busy    = (cnt_r != '0);
  assign last    = (cnt_r == {{(CW-1){1'b0}}, 1'b1});

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : ocd_clock_count

// ==== rtl/ocd_decode.sv ====
/*
 * opcode decoder and clock-count sequencer for the data-transfer and first
 * arithmetic group. assumes opcode and modrm are offered together with
 * insn_valid, the queue is prefilled and no wait states occur.
 */
`timescale 1ns/1ps
`include "ocd_regs.svh"

module ocd_decode
  import ocd_pkg::*;
(
  input  wire logic      ref_clk,     // core clock, 40 MHz
  input  wire logic      sys_rst,     // sync reset, high
  input  wire logic      insn_valid,  // opcode and modrm offered
  input  ocd_insn_t      insn,        // opcode and modrm bytes
  output logic           insn_ready,  // decoder can take an instruction
  output ocd_dec_t       dec,         // registered decode of taken insn
  output logic           dec_valid,   // one-cycle pulse the cycle after take
  output logic           exec_busy,   // instruction clocks running
  output logic           exec_done,   // one-cycle pulse on last clock
  output ocd_seg_t       pend_seg,    // pending override segment
  output logic           pend_ovr     // override pending for next insn
);

  // ------------------------------------------------------------
  // field extraction
  // ------------------------------------------------------------
  wire [7:0] op      = insn.opcode;
  wire [1:0] md      = insn.modrm[7:6];
  wire [2:0] mid     = insn.modrm[5:3];
  wire [2:0] rm      = insn.modrm[2:0];
  wire       is_mem  = (md != 2'b11);
  wire       w_bit   = op[0];
  wire       d_bit   = op[1];

  wire take;
  wire cnt_busy;
  wire cnt_last;
  ocd_dec_t d;

  wire grp_rm_sum    = (op[7:2] == 6'b000000);
  wire grp_rm_adc    = (op[7:2] == 6'b000100);
  wire grp_rm_sub    = (op[7:2] == 6'b001010);
  wire grp_rm_sbb    = (op[7:2] == 6'b000110);
  wire grp_rm_cmp    = (op[7:2] == 6'b001110);
  wire grp_imm_rm    = (op[7:2] == 6'b100000);
  wire grp_acc       = (op[7:6] == 2'b00) && (op[2:1] == 2'b10);
  wire grp_incdec    = (op[7:1] == 7'b1111111);
  wire grp_unary     = (op[7:1] == 7'b1111011);
  wire grp_short_inc = (op[7:3] == 5'b01000);
  wire grp_short_dec = (op[7:3] == 5'b01001);

  // ------------------------------------------------------------
  // combinational decode
  // ------------------------------------------------------------
  always_comb begin
    d              = '0;
    d.op           = OCD_ILLEGAL;
    d.word         = w_bit;
    d.reg_dest     = d_bit;
    d.reg_sel      = mid;
    d.seg          = pend_seg;
    d.seg_override = pend_ovr;
    d.clocks       = `OCD_T_UNKNOWN;
    if (grp_rm_sum || grp_rm_adc || grp_rm_sub || grp_rm_sbb || grp_rm_cmp) begin
      d.uses_modrm   = 1'b1;
      d.mem_operand  = is_mem;
      d.store_result = !grp_rm_cmp;
      d.clocks       = is_mem ? `OCD_T_ALU_M : `OCD_T_ALU_R;
      if (grp_rm_sum) begin
        d.op = OCD_SUM;
      end else if (grp_rm_adc) begin
        d.op       = OCD_SUM_CARRY;
        d.carry_in = 1'b1;
      end else if (grp_rm_sub) begin
        d.op = OCD_DIFF;
      end else if (grp_rm_sbb) begin
        d.op       = OCD_DIFF_BORROW;
        d.carry_in = 1'b1;
      end else begin
        d.op = OCD_COMPARE;
      end
    end else if (grp_imm_rm) begin
      d.uses_modrm   = 1'b1;
      d.mem_operand  = is_mem;
      d.has_imm      = 1'b1;
      d.reg_dest     = 1'b0;
      d.reg_sel      = rm;
      d.imm_bytes    = (op[1:0] == 2'b01) ? 2'd2 : 2'd1;
      d.store_result = 1'b1;
      d.clocks       = is_mem ? `OCD_T_IMM_M : `OCD_T_IMM_R;
      case (mid)
        3'b000: d.op = OCD_SUM;
        3'b010: begin
          d.op       = OCD_SUM_CARRY;
          d.carry_in = 1'b1;
        end
        3'b101: d.op = OCD_DIFF;
        3'b011: begin
          d.op       = OCD_DIFF_BORROW;
          d.carry_in = 1'b1;
        end
        3'b111: begin
          d.op           = OCD_COMPARE;
          d.store_result = 1'b0;
          d.clocks       = is_mem ? `OCD_T_ALU_M : `OCD_T_ALU_R;
        end
        default: begin
          d.op     = OCD_ILLEGAL;
          d.clocks = `OCD_T_UNKNOWN;
        end
      endcase
    end else if (grp_acc && op[5:3] != 3'b100 && op[5:3] != 3'b001 && op[5:3] != 3'b101
                 && op[5:3] != 3'b110 && op[5:3] != 3'b100) begin
      d.has_imm      = 1'b1;
      d.imm_bytes    = w_bit ? 2'd2 : 2'd1;
      d.reg_dest     = 1'b1;
      d.reg_sel      = 3'b000;
      d.store_result = (op[5:3] != 3'b111);
      d.clocks       = w_bit ? `OCD_T_ACC_W : `OCD_T_ACC_B;
      case (op[5:3])
        3'b000: d.op = OCD_SUM;
        3'b010: begin
          d.op       = OCD_SUM_CARRY;
          d.carry_in = 1'b1;
        end
        3'b011: begin
          d.op       = OCD_DIFF_BORROW;
          d.carry_in = 1'b1;
        end
        3'b111: d.op = OCD_COMPARE;
        default: d.op = OCD_ILLEGAL;
      endcase
    end else if (op == 8'h2c || op == 8'h2d) begin
      d.op           = OCD_DIFF;
      d.has_imm      = 1'b1;
      d.imm_bytes    = w_bit ? 2'd2 : 2'd1;
      d.reg_dest     = 1'b1;
      d.reg_sel      = 3'b000;
      d.store_result = 1'b1;
      d.clocks       = w_bit ? `OCD_T_ACC_W : `OCD_T_ACC_B;
    end else if (grp_incdec && (mid == 3'b000 || mid == 3'b001)) begin
      d.op           = (mid == 3'b000) ? OCD_PLUS_ONE : OCD_MINUS_ONE;
      d.uses_modrm   = 1'b1;
      d.mem_operand  = is_mem;
      d.reg_dest     = 1'b0;
      d.reg_sel      = rm;
      d.store_result = 1'b1;
      d.clocks       = is_mem ? `OCD_T_INCDEC_M : `OCD_T_INCDEC_R;
    end else if (grp_short_inc || grp_short_dec) begin
      d.op           = grp_short_inc ? OCD_PLUS_ONE : OCD_MINUS_ONE;
      d.word         = 1'b1;
      d.reg_dest     = 1'b1;
      d.reg_sel      = op[2:0];
      d.store_result = 1'b1;
      d.clocks       = `OCD_T_SHORT_INCDEC;
    end else if (grp_unary && mid == 3'b011) begin
      d.op           = OCD_SIGN_CHANGE;
      d.uses_modrm   = 1'b1;
      d.mem_operand  = is_mem;
      d.reg_dest     = 1'b0;
      d.reg_sel      = rm;
      d.store_result = 1'b1;
      d.clocks       = is_mem ? `OCD_T_NEG_M : `OCD_T_NEG_R;
    end else if (grp_unary && mid == 3'b100) begin
      d.op           = OCD_PRODUCT;
      d.uses_modrm   = 1'b1;
      d.mem_operand  = is_mem;
      d.reg_sel      = rm;
      d.store_result = 1'b1;
      case ({is_mem, w_bit})
        2'b00:   d.clocks = `OCD_T_MULB_R;
        2'b01:   d.clocks = `OCD_T_MULW_R;
        2'b10:   d.clocks = `OCD_T_MULB_M;
        default: d.clocks = `OCD_T_MULW_M;
      endcase
    end else begin
      case (op)
        `OCD_OP_SEG_FROM_RM: begin
          d.op          = OCD_SEG_LOAD;
          d.uses_modrm  = 1'b1;
          d.mem_operand = is_mem;
          d.word        = 1'b1;
          d.clocks      = is_mem ? `OCD_T_SEG_LD_M : `OCD_T_SEG_LD_R;
        end
        `OCD_OP_SEG_TO_RM: begin
          d.op           = OCD_SEG_STORE;
          d.uses_modrm   = 1'b1;
          d.mem_operand  = is_mem;
          d.word         = 1'b1;
          d.store_result = 1'b1;
          d.clocks       = is_mem ? `OCD_T_SEG_ST_M : `OCD_T_SEG_ST_R;
        end
        `OCD_OP_TABLE: begin
          d.op           = OCD_TABLE_LOOKUP;
          d.mem_operand  = 1'b1;
          d.word         = 1'b0;
          d.reg_sel      = 3'b000;
          d.store_result = 1'b1;
          d.clocks       = `OCD_T_TABLE;
        end
        `OCD_OP_EA_LOAD: begin
          d.uses_modrm   = 1'b1;
          d.word         = 1'b1;
          d.reg_dest     = 1'b1;
          d.store_result = is_mem;
          d.op           = is_mem ? OCD_EA_LOAD : OCD_ILLEGAL;
          d.clocks       = is_mem ? `OCD_T_EA_LOAD : `OCD_T_UNKNOWN;
        end
        `OCD_OP_FAR_DATA, `OCD_OP_FAR_EXTRA: begin
          d.uses_modrm   = 1'b1;
          d.mem_operand  = is_mem;
          d.word         = 1'b1;
          d.reg_dest     = 1'b1;
          d.store_result = is_mem;
          d.op           = !is_mem ? OCD_ILLEGAL : (op[0] ? OCD_FAR_DATA : OCD_FAR_EXTRA);
          d.clocks       = is_mem ? `OCD_T_FAR_PTR : `OCD_T_UNKNOWN;
        end
        `OCD_OP_FLAGS_TO_AH: begin
          d.op           = OCD_FLAGS_TO_AH;
          d.word         = 1'b0;
          d.reg_sel      = 3'b100;
          d.store_result = 1'b1;
          d.clocks       = `OCD_T_FLAGS_TO_AH;
        end
        `OCD_OP_AH_TO_FLAGS: begin
          d.op      = OCD_AH_TO_FLAGS;
          d.word    = 1'b0;
          d.reg_sel = 3'b100;
          d.clocks  = `OCD_T_AH_TO_FLAGS;
        end
        `OCD_OP_PFX_CODE, `OCD_OP_PFX_STACK, `OCD_OP_PFX_DATA, `OCD_OP_PFX_EXTRA: begin
          d.op     = OCD_SEG_PREFIX;
          d.seg    = ocd_seg_t'(op[4:3]);
          d.clocks = `OCD_T_PREFIX;
        end
        `OCD_OP_ASCII_SUM: begin
          d.op     = OCD_ASCII_SUM_FIX;
          d.clocks = `OCD_T_ASCII_SUM;
        end
        `OCD_OP_BCD_SUM: begin
          d.op     = OCD_BCD_SUM_FIX;
          d.clocks = `OCD_T_BCD_FIX;
        end
        `OCD_OP_ASCII_DIFF: begin
          d.op     = OCD_ASCII_DIFF_FIX;
          d.clocks = `OCD_T_ASCII_DIFF;
        end
        `OCD_OP_BCD_DIFF: begin
          d.op     = OCD_BCD_DIFF_FIX;
          d.clocks = `OCD_T_BCD_FIX;
        end
        default: begin
          d.op     = OCD_ILLEGAL;
          d.clocks = `OCD_T_UNKNOWN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // issue and override tracking
  // ------------------------------------------------------------
  assign insn_ready = !cnt_busy || cnt_last;
  assign take       = insn_valid && insn_ready;
  assign exec_busy  = cnt_busy;
  assign exec_done  = cnt_last;

  ocd_seg_t seg_r;
  logic     ovr_r;
  assign pend_seg = seg_r;
  assign pend_ovr = ovr_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dec       <= '0;
      dec_valid <= 1'b0;
      seg_r     <= OCD_SEG_DATA;
      ovr_r     <= 1'b0;
    end else begin
      dec_valid <= take;
      if (take) begin
        dec <= d;
      end
      if (take) begin
        ovr_r <= (d.op == OCD_SEG_PREFIX);
        seg_r <= (d.op == OCD_SEG_PREFIX) ? d.seg : OCD_SEG_DATA;
      end
    end
  end

  ocd_clock_count #(
    .CW (7)
  ) u_count (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .load    (take),
    .clocks  (d.clocks),
    .busy    (cnt_busy),
    .last    (cnt_last)
  );

endmodule : ocd_decode
